// ---- crim_pkg.sv ----
// Shared types and constants for the CAN reset/initialization mode control.
// Assumes a single 200 MHz clock domain and no software-visible register bus.
package crim_pkg;

  typedef enum logic [1:0] {
    CRIM_MODE_RESET,
    CRIM_MODE_OPER,
    CRIM_MODE_SLEEP,
    CRIM_MODE_IFSLEEP
  } crim_mode_t;

  localparam int unsigned CLK_MHZ = 200;

  localparam int unsigned ERR_CNT_W = 8;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_RST = 8'h00;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_MAX = 8'hff;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_ONE = 8'h01;

  localparam int unsigned TS_W = 16;
  localparam logic [TS_W-1:0] TS_RST = 16'h0000;
  localparam logic [TS_W-1:0] TS_ONE = 16'h0001;

  // Message box memory: 16 boxes of 16 bytes
  localparam int unsigned MB_ADDR_W = 8;
  localparam int unsigned MB_DATA_W = 8;
  localparam int unsigned MB_DEPTH = 256;
  localparam logic [MB_DATA_W-1:0] MB_RDATA_RST = 8'h00;

  localparam logic CAN_RECESSIVE = 1'b1;

endpackage

// ---- crim_msgbox_mem.sv ----
// Message box memory with a registered read port.
// Assumes the caller gates nothing: access is open in every mode.
`timescale 1ns/100ps
module crim_msgbox_mem
  import crim_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic wr,
  input wire logic rd,
  input wire logic [MB_ADDR_W-1:0] addr,
  input wire logic [MB_DATA_W-1:0] wdata,
  output logic [MB_DATA_W-1:0] rdata_q
);

  // Contents survive the reset mode, so the array itself has no reset
  logic [MB_DATA_W-1:0] mem [MB_DEPTH];

  always_ff @(posedge clk)
  begin
    if (en && wr)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= MB_RDATA_RST;
    end
    else if (en && rd)
    begin
      rdata_q <= mem[addr];
    end
  end

endmodule // crim_msgbox_mem

// ---- crim_mode_ctrl.sv ----
// Operating mode control of a CAN controller, centred on reset/init mode.
// Assumes software bits arrive as same-clock levels and the CAN rx pin is async.
//
// Notes on behaviour
// [RULE_01] Four modes: reset, operating, sleep, interface sleep
// [RULE_02] Device reset or request bit enters reset mode
// [RULE_03] Software polls state flag until it reads one
// [RULE_04] No bus transmit or receive in reset mode
// [RULE_05] Defer entry until ongoing transmission ends
// [RULE_06] Clear and lock status, counters, timestamp on entry
// [RULE_07] Config, masks, message memory kept and accessible
// [RULE_08] Clearing request bit returns to operating, unlocks
`timescale 1ns/100ps
module crim_mode_ctrl
  import crim_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic reset_req,
  input wire logic sleep_req,
  input wire logic if_sleep_req,
  input wire logic tx_busy,
  input wire logic tx_end,
  input wire logic tx_err_evt,
  input wire logic rx_err_evt,
  input wire logic bit_tick,
  input wire logic tx_bit,
  input wire logic can_rx_pin,
  input wire logic mb_wr,
  input wire logic mb_rd,
  input wire logic [MB_ADDR_W-1:0] mb_addr,
  input wire logic [MB_DATA_W-1:0] mb_wdata,
  output crim_mode_t mode_q,
  output logic state_reset_q,
  output logic regs_lock_q,
  output logic regs_init_q,
  output logic can_tx_pin_q,
  output logic rx_bit_q,
  output logic [ERR_CNT_W-1:0] tx_error_counter_q,
  output logic [ERR_CNT_W-1:0] rx_error_counter_q,
  output logic [TS_W-1:0] timestamp_reg_q,
  output logic [MB_DATA_W-1:0] mb_rdata_q
);

  function automatic logic comm_on(input crim_mode_t m);
    comm_on = (m == CRIM_MODE_OPER);
  endfunction

  function automatic logic [ERR_CNT_W-1:0] sat_inc(input logic [ERR_CNT_W-1:0] v);
    sat_inc = (v == ERR_CNT_MAX) ? v : v + ERR_CNT_ONE;
  endfunction

  crim_mode_t mode_d;
  logic enter_reset;
  logic tx_quiet;
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_filt_q;

  // A frame in flight blocks entry until it ends in any way
  assign tx_quiet = !tx_busy || tx_end;
  assign enter_reset = (mode_d == CRIM_MODE_RESET) && (mode_q != CRIM_MODE_RESET);

  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      CRIM_MODE_RESET:
      begin
        if (!reset_req)
        begin
          mode_d = CRIM_MODE_OPER; // see [RULE_08]
        end
      end
      CRIM_MODE_OPER:
      begin
        if (reset_req)
        begin
          if (tx_quiet)
          begin
            mode_d = CRIM_MODE_RESET; // see [RULE_05]
          end
        end
        else if (sleep_req)
        begin
          mode_d = CRIM_MODE_SLEEP; // see [RULE_01]
        end
        else if (if_sleep_req)
        begin
          mode_d = CRIM_MODE_IFSLEEP; // see [RULE_01]
        end
      end
      CRIM_MODE_SLEEP, CRIM_MODE_IFSLEEP:
      begin
        // Nothing is on the bus here, so a reset request acts at once
        if (reset_req)
        begin
          mode_d = CRIM_MODE_RESET; // see [RULE_02]
        end
        else if (!sleep_req && !if_sleep_req)
        begin
          mode_d = CRIM_MODE_OPER;
        end
      end
      default:
      begin
        mode_d = CRIM_MODE_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= CRIM_MODE_RESET; // see [RULE_02]
      state_reset_q <= 1'b1;
      regs_lock_q <= 1'b1;
    end
    else if (en)
    begin
      mode_q <= mode_d;
      state_reset_q <= (mode_d == CRIM_MODE_RESET); // see [RULE_05]
      regs_lock_q <= (mode_d == CRIM_MODE_RESET); // see [RULE_06] [RULE_08]
    end
  end

  // Pulse tells the other locked registers to load their reset values
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regs_init_q <= 1'b1;
    end
    else if (en)
    begin
      regs_init_q <= enter_reset; // see [RULE_06]
    end
  end

  // Three-stage synchroniser; value moves only once stages two and three agree
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_s1_q <= CAN_RECESSIVE;
      rx_s2_q <= CAN_RECESSIVE;
      rx_s3_q <= CAN_RECESSIVE;
      rx_filt_q <= CAN_RECESSIVE;
    end
    else if (en)
    begin
      rx_s1_q <= can_rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q)
      begin
        rx_filt_q <= rx_s3_q;
      end
    end
  end

  // Gated on the next mode so the bus is released on the entry edge itself
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      can_tx_pin_q <= CAN_RECESSIVE;
      rx_bit_q <= CAN_RECESSIVE;
    end
    else if (en)
    begin
      can_tx_pin_q <= comm_on(mode_d) ? tx_bit : CAN_RECESSIVE; // see [RULE_04]
      rx_bit_q <= comm_on(mode_d) ? rx_filt_q : CAN_RECESSIVE; // see [RULE_04]
    end
  end

  // Counters hold their cleared value for as long as the lock stands
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_error_counter_q <= ERR_CNT_RST;
      rx_error_counter_q <= ERR_CNT_RST;
    end
    else if (en)
    begin
      if (mode_d == CRIM_MODE_RESET)
      begin
        tx_error_counter_q <= ERR_CNT_RST; // see [RULE_06]
        rx_error_counter_q <= ERR_CNT_RST; // see [RULE_06]
      end
      else if (comm_on(mode_q))
      begin
        if (tx_err_evt)
        begin
          tx_error_counter_q <= sat_inc(tx_error_counter_q);
        end
        if (rx_err_evt)
        begin
          rx_error_counter_q <= sat_inc(rx_error_counter_q);
        end
      end
    end
  end

  // Timestamp wraps freely; only bit ticks in operating mode advance it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timestamp_reg_q <= TS_RST;
    end
    else if (en)
    begin
      if (mode_d == CRIM_MODE_RESET)
      begin
        timestamp_reg_q <= TS_RST; // see [RULE_06]
      end
      else if (comm_on(mode_q) && bit_tick)
      begin
        timestamp_reg_q <= timestamp_reg_q + TS_ONE;
      end
    end
  end

  // Memory is never locked, whatever the mode
  crim_msgbox_mem u_msgbox_mem ( // see [RULE_07]
    .clk(clk),
    .nrst(nrst),
    .en(en),
    .wr(mb_wr),
    .rd(mb_rd),
    .addr(mb_addr),
    .wdata(mb_wdata),
    .rdata_q(mb_rdata_q)
  );

  property p_reset_entry;
    @(posedge clk) disable iff (!nrst)
    (en && reset_req && !tx_busy && mode_q != CRIM_MODE_RESET)
      |=> (mode_q == CRIM_MODE_RESET && state_reset_q && regs_init_q);
  endproperty
  a_reset_entry: assert property (p_reset_entry) // see [RULE_02]
    else $error("Reset request did not enter reset mode");

  property p_defer;
    @(posedge clk) disable iff (!nrst)
    (en && mode_q == CRIM_MODE_OPER && reset_req && tx_busy && !tx_end)
      |=> (mode_q == CRIM_MODE_OPER && !state_reset_q);
  endproperty
  a_defer: assert property (p_defer) // see [RULE_05]
    else $error("Reset mode entered during a transmission");

  property p_flag_cause;
    @(posedge clk) disable iff (!nrst)
    $rose(state_reset_q) |-> $past(tx_quiet) && $past(reset_req);
  endproperty
  a_flag_cause: assert property (p_flag_cause) // see [RULE_05]
    else $error("State flag set without quiet transmitter");

  property p_bus_quiet;
    @(posedge clk) disable iff (!nrst)
    (mode_q != CRIM_MODE_OPER) |-> (can_tx_pin_q == CAN_RECESSIVE && rx_bit_q == CAN_RECESSIVE);
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) // see [RULE_04]
    else $error("Bus traffic outside operating mode");

  property p_locked_clear;
    @(posedge clk) disable iff (!nrst)
    regs_lock_q |-> (tx_error_counter_q == ERR_CNT_RST && rx_error_counter_q == ERR_CNT_RST
      && timestamp_reg_q == TS_RST);
  endproperty
  a_locked_clear: assert property (p_locked_clear) // see [RULE_06]
    else $error("Locked register not at its reset value");

  property p_mem_open;
    @(posedge clk) disable iff (!nrst)
    (en && mb_wr && !mb_rd && regs_lock_q)
      ##1 (en && mb_rd && !mb_wr && mb_addr == $past(mb_addr))
      |=> (mb_rdata_q == $past(mb_wdata, 2));
  endproperty
  a_mem_open: assert property (p_mem_open) // see [RULE_07]
    else $error("Message memory not accessible in reset mode");

  property p_leave;
    @(posedge clk) disable iff (!nrst)
    (en && mode_q == CRIM_MODE_RESET && !reset_req)
      |=> (mode_q == CRIM_MODE_OPER && !state_reset_q && !regs_lock_q);
  endproperty
  a_leave: assert property (p_leave) // see [RULE_08]
    else $error("Clearing the request did not leave reset mode");

  property p_sleep;
    @(posedge clk) disable iff (!nrst)
    (en && mode_q == CRIM_MODE_OPER && !reset_req && sleep_req)
      |=> (mode_q == CRIM_MODE_SLEEP);
  endproperty
  a_sleep: assert property (p_sleep) // see [RULE_01]
    else $error("Sleep request ignored in operating mode");

endmodule // crim_mode_ctrl

// ---- crim_can_node.sv ----
// Far-side CAN node: pulls the bus dominant on request, wired-AND with the device.
// Assumes a pull-up keeps the bus recessive while nobody drives it low.
`timescale 1ns/100ps
module crim_can_node
  import crim_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic dom_req,
  input wire logic dut_tx,
  output logic bus
);
  logic node_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      node_q <= CAN_RECESSIVE;
    end
    else
    begin
      node_q <= ~dom_req;
    end
  end

  // Dominant wins, so either party can pull the shared line low
  assign bus = node_q & dut_tx;
endmodule // crim_can_node

// ---- tb_can_reset_init_mode_control.sv ----
// Bench for the CAN reset/init mode control: modes, deferral, locks, pins, memory.
// Assumes crim_pkg and the design files are compiled first; one 200 MHz clock.
`timescale 1ns/100ps
module tb_can_reset_init_mode_control
  import crim_pkg::*;
();
  logic clk, nrst, en, reset_req, sleep_req, if_sleep_req, tx_busy, tx_end;
  logic tx_err_evt, rx_err_evt, bit_tick, tx_bit, can_rx_pin, mb_wr, mb_rd, dom_req;
  logic [MB_ADDR_W-1:0] mb_addr;
  logic [MB_DATA_W-1:0] mb_wdata, mb_rdata_q;
  crim_mode_t mode_q;
  logic state_reset_q, regs_lock_q, regs_init_q, can_tx_pin_q, rx_bit_q, rd_d;
  logic [ERR_CNT_W-1:0] tx_cnt, rx_cnt;
  logic [TS_W-1:0] ts;
  logic [31:0] lfsr;
  logic [MB_DATA_W-1:0] exp_q[$];
  int mismatches, checks;

  crim_mode_ctrl u_crim_mode_ctrl (.clk(clk), .nrst(nrst), .en(en), .reset_req(reset_req),
    .sleep_req(sleep_req), .if_sleep_req(if_sleep_req), .tx_busy(tx_busy), .tx_end(tx_end),
    .tx_err_evt(tx_err_evt), .rx_err_evt(rx_err_evt), .bit_tick(bit_tick), .tx_bit(tx_bit),
    .can_rx_pin(can_rx_pin), .mb_wr(mb_wr), .mb_rd(mb_rd), .mb_addr(mb_addr),
    .mb_wdata(mb_wdata), .mode_q(mode_q), .state_reset_q(state_reset_q),
    .regs_lock_q(regs_lock_q), .regs_init_q(regs_init_q), .can_tx_pin_q(can_tx_pin_q),
    .rx_bit_q(rx_bit_q), .tx_error_counter_q(tx_cnt), .rx_error_counter_q(rx_cnt),
    .timestamp_reg_q(ts), .mb_rdata_q(mb_rdata_q));

  crim_can_node u_crim_can_node (.clk(clk), .nrst(nrst), .dom_req(dom_req),
    .dut_tx(can_tx_pin_q), .bus(can_rx_pin));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic st(input crim_mode_t m, input logic f);
    @(negedge clk);
    chk("mode", 16'(mode_q), 16'(m));
    chk("flag", {15'h0, state_reset_q}, {15'h0, f});
    chk("lock", {15'h0, regs_lock_q}, {15'h0, f});
  endtask

  task automatic cnts(input logic [7:0] e);
    chk("tx_cnt", {8'h00, tx_cnt}, {8'h00, e});
    chk("rx_cnt", {8'h00, rx_cnt}, {8'h00, e});
    chk("stamp", ts, {8'h00, e});
  endtask

  task automatic evts(input int n);
    repeat (n)
    begin
      @(posedge clk);
      {tx_err_evt, rx_err_evt, bit_tick} <= 3'h7;
      @(posedge clk);
      {tx_err_evt, rx_err_evt, bit_tick} <= 3'h0;
    end
  endtask

  // Software side waits on the flag, never on a fixed delay
  task automatic poll(input logic f);
    int i;
    for (i = 0; i < 20 && state_reset_q !== f; i++) @(negedge clk);
    if (state_reset_q !== f)
    begin
      mismatches++;
      finish_test();
    end
  endtask

  // Write then read back on the very next edge
  task automatic mem(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    mb_wr <= 1'b1;
    mb_addr <= a;
    mb_wdata <= d;
    @(posedge clk);
    mb_wr <= 1'b0;
    mb_rd <= 1'b1;
    exp_q.push_back(d);
    @(posedge clk);
    mb_rd <= 1'b0;
  endtask

  always @(posedge clk) rd_d <= mb_rd;

  always @(negedge clk)
  begin
    if (rd_d === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("spare_read", 16'h1, 16'h0);
      else
        chk("mb_rdata", {8'h00, mb_rdata_q}, {8'h00, exp_q.pop_front()});
    end
  end

  initial
  begin
    lfsr = 32'hcb395351;
    {nrst, en, reset_req, sleep_req, if_sleep_req, tx_busy, tx_end} = 7'b0110000;
    {tx_err_evt, rx_err_evt, bit_tick, tx_bit, mb_wr, mb_rd, dom_req} = 7'b0001000;
    mb_addr = 8'h00;
    mb_wdata = 8'h00;
    mismatches = 0;
    checks = 0;
    tick(20);
    nrst <= 1'b1;
    st(CRIM_MODE_RESET, 1'b1);
    cnts(8'h00);
    @(posedge clk);
    reset_req <= 1'b0;
    tick(1);
    st(CRIM_MODE_OPER, 1'b0);
    repeat (8)
    begin
      @(posedge clk);
      lfsr = lfsr_next(lfsr);
      tx_bit <= lfsr[0];
      tick(2);
      @(negedge clk);
      chk("tx_pin", {15'h0, can_tx_pin_q}, {15'h0, lfsr[0]});
    end
    evts(3);
    @(negedge clk);
    cnts(8'h03);
    @(posedge clk);
    tx_busy <= 1'b1;
    reset_req <= 1'b1;
    tick(3);
    st(CRIM_MODE_OPER, 1'b0);
    @(posedge clk);
    tx_end <= 1'b1;
    @(posedge clk);
    {tx_end, tx_busy} <= 2'b00;
    st(CRIM_MODE_RESET, 1'b1);
    chk("init", {15'h0, regs_init_q}, 16'h1);
    cnts(8'h00);
    @(posedge clk);
    {tx_bit, dom_req} <= 2'b01;
    evts(2);
    tick(6);
    @(negedge clk);
    cnts(8'h00);
    chk("init", {15'h0, regs_init_q}, 16'h0);
    chk("tx_pin", {15'h0, can_tx_pin_q}, 16'h1);
    chk("rx_bit", {15'h0, rx_bit_q}, 16'h1);
    repeat (4)
    begin
      lfsr = lfsr_next(lfsr);
      mem(lfsr[7:0], lfsr[15:8]);
    end
    @(posedge clk);
    {reset_req, tx_bit} <= 2'b01;
    tick(1);
    st(CRIM_MODE_OPER, 1'b0);
    tick(8);
    @(negedge clk);
    chk("rx_bit", {15'h0, rx_bit_q}, 16'h0);
    @(posedge clk);
    {dom_req, sleep_req} <= 2'b01;
    tick(1);
    st(CRIM_MODE_SLEEP, 1'b0);
    @(posedge clk);
    sleep_req <= 1'b0;
    tick(1);
    st(CRIM_MODE_OPER, 1'b0);
    @(posedge clk);
    if_sleep_req <= 1'b1;
    tick(1);
    st(CRIM_MODE_IFSLEEP, 1'b0);
    @(posedge clk);
    reset_req <= 1'b1;
    poll(1'b1);
    st(CRIM_MODE_RESET, 1'b1);
    // Low enable must hold mode, flag and counters through a request
    @(posedge clk);
    {reset_req, if_sleep_req} <= 2'b00;
    tick(1);
    st(CRIM_MODE_OPER, 1'b0);
    evts(1);
    @(posedge clk);
    en <= 1'b0;
    reset_req <= 1'b1;
    evts(2);
    tick(2);
    st(CRIM_MODE_OPER, 1'b0);
    cnts(8'h01);
    @(posedge clk);
    en <= 1'b1;
    tick(1);
    st(CRIM_MODE_RESET, 1'b1);
    cnts(8'h00);
    // Device reset in mid-run clears counters at once
    @(posedge clk);
    reset_req <= 1'b0;
    evts(1);
    @(negedge clk);
    cnts(8'h01);
    @(posedge clk);
    nrst <= 1'b0;
    st(CRIM_MODE_RESET, 1'b1);
    cnts(8'h00);
    @(posedge clk);
    nrst <= 1'b1;
    st(CRIM_MODE_RESET, 1'b1);
    st(CRIM_MODE_OPER, 1'b0);
    chk("init", {15'h0, regs_init_q}, 16'h0);
    tick(2);
    chk("pending", 16'(exp_q.size()), 16'h0);
    finish_test();
  end
endmodule // tb_can_reset_init_mode_control
